// >>> src/pcs_clock_ctrl.sv
// Contract
// - straps are sampled only while reset is held, ignored afterwards.
// - strap pair sets defaults: supply low bypasses loop; 10 gives x4, 11 gives x401.
// - loop enable comes only from reset straps, software cannot enable it.
// - reference multiplied by a 12-bit software factor, 1 through 4096.
// - changing the factor drops lock, clocks stop until relock within 2500 periods.
// - system clock passes the low-power divider; baud clock bypasses it.
// - non-zero divide means slow-go; divide changes act at once, lock kept.
// - divider only applies with loop active; else reference undivided.
// - divider resets to divide-by-one.
// - operation mode register has a write lock bit blocking later writes.
// - control register 16 bits at 0F8: lock, drive mode, enable, factor.
// - on 8-bit bus low byte first; high byte write applies settings.
// - while control write lock is set all writes to it are blocked.
// - reset loads enable, factor bits 8,7,4 and 1,0 from the straps.
// - multiplier equals field plus one.
// - drive mode 00 full, 01 two-thirds, 10 one-third, 11 off held high.
// - write lock resets to zero; the setting write itself completes.
// - software cannot clear loop enable; only the supply strap low at reset.
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_clock_ctrl (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              loop_supply_strap,
  input  wire logic              boot_freq_select_pin,
  input  wire logic              bus_width_strap,
  input  wire logic              bus_sel,
  input  wire logic              bus_we,
  input  wire logic [7:0]        bus_addr,
  input  wire logic              bus_ub,
  input  wire logic              bus_lb,
  input  wire logic [15:0]       bus_wdata,
  output logic      [15:0]       bus_rdata_r,
  output logic                   sys_clk_en_r,
  output logic                   baud_clk_en_r,
  output logic                   pll_locked_r,
  output logic      [11:0]       multiply_factor_r,
  output logic      [1:0]        clock_out_drive_mode_r,
  output logic                   clock_out_hold_high_r,
  output pcs_pkg::pcs_lock_t     lock_state_r
);
  import pcs_pkg::*;

  localparam int RELOCK = `PCS_RELOCK_CYCLES;

  logic                 wp_r, wp_nxt;
  logic [1:0]           drv_nxt;
  logic                 loop_en_r;
  logic [11:0]          fac_nxt;
  logic [7:0]           stage_r, stage_nxt;
  logic                 bus8_r;
  logic                 omcr_wp_r, omcr_wp_nxt;
  logic [3:0]           div_r, div_nxt;
  pcs_lock_t            st_nxt;
  logic [11:0]          cnt_r, cnt_nxt;
  logic [15:0]          rdata_nxt;
  logic                 wr_pl, wr_om, commit, fac_change, tick;
  logic [15:0]          cand;

  always_comb begin
    wr_pl = bus_sel && bus_we && (bus_addr == `PCS_PLCR_OFS);
    wr_om = bus_sel && bus_we && (bus_addr == `PCS_OMCR_OFS) && bus_ub;
    wp_nxt = wp_r;
    drv_nxt = clock_out_drive_mode_r;
    fac_nxt = multiply_factor_r;
    stage_nxt = stage_r;
    omcr_wp_nxt = omcr_wp_r;
    div_nxt = div_r;
    // 8-bit bus: low byte is only staged, the high byte commits both
    commit = 1'b0;
    cand = {wp_r, clock_out_drive_mode_r, loop_en_r, multiply_factor_r};
    if (wr_pl && !wp_r) begin
      if (bus8_r) begin
        if (bus_lb) begin
          stage_nxt = bus_wdata[7:0];
        end
        if (bus_ub) begin
          commit = 1'b1;
          cand = {bus_wdata[15:8], stage_r};
        end
      end else begin
        commit = bus_ub || bus_lb;
        if (bus_ub) begin
          cand[15:8] = bus_wdata[15:8];
        end
        if (bus_lb) begin
          cand[7:0] = bus_wdata[7:0];
        end
      end
    end
    if (commit) begin
      wp_nxt = cand[`PCS_WP_BIT];
      drv_nxt = cand[`PCS_DRV_HI:`PCS_DRV_LO];
      fac_nxt = cand[`PCS_FAC_HI:0];
    end
    // enable bit is never written from the bus
    fac_change = commit && (cand[`PCS_FAC_HI:0] != multiply_factor_r);
    if (wr_om && !omcr_wp_r) begin
      omcr_wp_nxt = bus_wdata[8 + `PCS_OMCR_WP_BIT];
      div_nxt = bus_wdata[8 +: `PCS_DIV_W];
    end
  end

  // lock model: reference is mclk, relock takes the full worst case
  always_comb begin
    st_nxt = lock_state_r;
    cnt_nxt = cnt_r;
    case (lock_state_r)
      LK_OFF: begin
        st_nxt = LK_OFF;
      end
      LK_RUN: begin
        if (fac_change) begin
          st_nxt = LK_ACQ;
          cnt_nxt = 12'(RELOCK - 1);
        end
      end
      default: begin
        if (fac_change) begin
          cnt_nxt = 12'(RELOCK - 1);
        end else if (cnt_r == '0) begin
          st_nxt = LK_RUN;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
    endcase
  end

  pcs_lp_divider u_div (
    .mclk (mclk),
    .nrst (nrst),
    .run  (lock_state_r == LK_RUN),
    .div  (div_r),
    .tick (tick)
  );

  always_comb begin
    rdata_nxt = 16'h0000;
    if (bus_sel && !bus_we && bus_addr == `PCS_PLCR_OFS) begin
      rdata_nxt = {wp_r, clock_out_drive_mode_r, loop_en_r, multiply_factor_r};
    end else if (bus_sel && !bus_we && bus_addr == `PCS_OMCR_OFS) begin
      rdata_nxt = {omcr_wp_r, 3'h0, div_r, 8'h00};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // straps land here only while reset is held
      loop_en_r <= loop_supply_strap;
      bus8_r <= !bus_width_strap;
      wp_r <= 1'b0;
      clock_out_drive_mode_r <= `PCS_DRV_RST;
      clock_out_hold_high_r <= 1'b0;
      multiply_factor_r <= !loop_supply_strap ? `PCS_FAC_RST_OFF :
                           (boot_freq_select_pin ? `PCS_FAC_RST_X401 : `PCS_FAC_RST_X4);
      stage_r <= 8'h00;
      omcr_wp_r <= 1'b0;
      div_r <= `PCS_DIV_RST;
      lock_state_r <= loop_supply_strap ? LK_ACQ : LK_OFF;
      cnt_r <= 12'(RELOCK - 1);
      bus_rdata_r <= 16'h0000;
      sys_clk_en_r <= 1'b0;
      baud_clk_en_r <= 1'b0;
      pll_locked_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      clock_out_drive_mode_r <= drv_nxt;
      clock_out_hold_high_r <= (drv_nxt == `PCS_DRV_OFF);
      multiply_factor_r <= fac_nxt;
      stage_r <= stage_nxt;
      omcr_wp_r <= omcr_wp_nxt;
      div_r <= div_nxt;
      lock_state_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bus_rdata_r <= rdata_nxt;
      // gated from registered lock: whole pulses only
      sys_clk_en_r <= loop_en_r ? tick : 1'b1;
      baud_clk_en_r <= loop_en_r ? (lock_state_r == LK_RUN) : 1'b1;
      pll_locked_r <= (lock_state_r == LK_RUN);
    end
  end

  // helper: cycles spent acquiring
  logic [12:0] acq_len_r;
  always_ff @(posedge mclk) begin
    if (!nrst || lock_state_r != LK_ACQ || fac_change) begin
      acq_len_r <= 13'h0000;
    end else begin
      acq_len_r <= acq_len_r + 13'h0001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_lo_only;
    bus8_r && wr_pl && bus_lb && !bus_ub;
  endsequence
  sequence s_fac_hit;
    lock_state_r == LK_RUN && fac_change;
  endsequence

  chk_enable_fixed: assert property (##1 loop_en_r == $past(loop_en_r))
    else $error("loop enable changed after reset");
  // a full 2500 cycles in acquire is still inside the bound
  chk_relock_bound: assert property (acq_len_r <= 13'(RELOCK))
    else $error("relock took longer than allowed");
  chk_clocks_stop: assert property (
    s_fac_hit |=> ##1 (!sys_clk_en_r && !baud_clk_en_r)[*8])
    else $error("derived clocks ran while unlocked");
  chk_bypass_off: assert property (!loop_en_r |=> sys_clk_en_r && baud_clk_en_r)
    else $error("disabled loop did not pass reference");
  chk_pl_protect: assert property (wp_r |=> $stable(multiply_factor_r) && wp_r)
    else $error("protected control register changed");
  chk_om_protect: assert property (omcr_wp_r |=> $stable(div_r))
    else $error("protected mode register changed");
  chk_byte_order: assert property (s_lo_only |=> $stable(multiply_factor_r))
    else $error("low byte alone changed the factor");
  chk_slow_gap: assert property (
    sys_clk_en_r && loop_en_r && div_r != 4'h0 && $stable(div_r) |=> !sys_clk_en_r)
    else $error("slow-go tick not divided");
  chk_drive_off: assert property (
    clock_out_hold_high_r == (clock_out_drive_mode_r == 2'h3))
    else $error("clock out hold mismatched drive mode");
endmodule : pcs_clock_ctrl

// >>> src/pcs_defines.svh
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

`define PCS_PLCR_OFS      8'hF8
`define PCS_OMCR_OFS      8'hFA
`define PCS_WP_BIT        15
`define PCS_DRV_HI        14
`define PCS_DRV_LO        13
`define PCS_LOOP_EN_BIT   12
`define PCS_FAC_HI        11
`define PCS_FAC_W         12
`define PCS_DIV_W         4
`define PCS_OMCR_WP_BIT   7
`define PCS_FAC_RST_OFF   12'h000
`define PCS_FAC_RST_X4    12'h003
`define PCS_FAC_RST_X401  12'h190
`define PCS_DIV_RST       4'h0
`define PCS_DRV_RST       2'h0
`define PCS_DRV_OFF       2'h3
`define PCS_MCLK_PERIOD_NS 50
`define PCS_REF_PERIOD_NS 50
`define PCS_RELOCK_REF_PERIODS 2500
`define PCS_RELOCK_NS     (`PCS_RELOCK_REF_PERIODS * `PCS_REF_PERIOD_NS)
`define PCS_RELOCK_CYCLES (`PCS_RELOCK_NS / `PCS_MCLK_PERIOD_NS)

`endif

// >>> src/pcs_lp_divider.sv
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_lp_divider (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  run,
  input  wire logic [`PCS_DIV_W-1:0] div,
  output logic                       tick
);
  logic [`PCS_DIV_W-1:0] cnt_r;
  logic [`PCS_DIV_W-1:0] cnt_nxt;

  // a new divide value takes hold at once; the count wraps as soon as it is at or above it
  always_comb begin
    tick = run && (cnt_r == '0);
    if (!run || cnt_r >= div) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : pcs_lp_divider

// >>> src/pcs_pkg.sv
package pcs_pkg;
  typedef enum logic [1:0] {
    LK_OFF,
    LK_ACQ,
    LK_RUN
  } pcs_lock_t;
endpackage : pcs_pkg

// >>> testbench/pcs_ref_osc.sv
`timescale 1ns/1ps
// free-running reference; the loop reference and the bench clock are the same net
module pcs_ref_osc #(
  parameter int HALF_NS = 25
) (
  output logic ref_clk
);
  initial ref_clk = 1'b0;
  // runs free, a crystal does not stop between accesses
  always #HALF_NS ref_clk = ~ref_clk;
endmodule : pcs_ref_osc

// >>> testbench/tb_pll_clock_synthesis_control.sv
`timescale 1ns/1ps
module tb_pll_clock_synthesis_control;
  import pcs_pkg::*;
  logic        mclk, nrst, sup, fsel, bw, sel, we, ub, lb;
  logic        sys_en, baud_en, locked, hold_hi;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [11:0] fac;
  logic [1:0]  drv;
  pcs_lock_t   lk;
  int          mismatches = 0, tests_run = 0, n_sys, n_baud, i;
  // write, readback, drive mode, held high
  logic [15:0] rows [4][4] = '{'{16'h6005, 16'h7005, 16'h0003, 16'h0001},
                               '{16'h0FFF, 16'h1FFF, 16'h0000, 16'h0000},
                               '{16'h8123, 16'h9123, 16'h0000, 16'h0000},
                               '{16'h0001, 16'h9123, 16'h0000, 16'h0000}};

  pcs_ref_osc osc (.ref_clk(mclk));
  pcs_clock_ctrl uut (
    .mclk(mclk), .nrst(nrst), .loop_supply_strap(sup), .boot_freq_select_pin(fsel),
    .bus_width_strap(bw), .bus_sel(sel), .bus_we(we), .bus_addr(addr), .bus_ub(ub),
    .bus_lb(lb), .bus_wdata(wdata), .bus_rdata_r(rdata), .sys_clk_en_r(sys_en),
    .baud_clk_en_r(baud_en), .pll_locked_r(locked), .multiply_factor_r(fac),
    .clock_out_drive_mode_r(drv), .clock_out_hold_high_r(hold_hi), .lock_state_r(lk));

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // inputs move 5 ns after the rising edge
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : tick

  // released data shows the inverse, not a stale copy
  task automatic wr(logic [7:0] a, logic [15:0] d, logic u, logic l);
    sel = 1;
    we = 1;
    addr = a;
    wdata = d;
    ub = u;
    lb = l;
    tick(1);
    sel = 0;
    wdata = ~d;
    tick(1);
  endtask : wr

  task automatic rchk(logic [7:0] a, logic [15:0] exp);
    sel = 1;
    we = 0;
    addr = a;
    tick(1);
    chk("read", exp, rdata);
    sel = 0;
    tick(1);
  endtask : rchk

  // straps flipped after release must leave no trace
  task automatic rst(logic s, logic m, logic b);
    nrst = 0;
    sup = s;
    fsel = m;
    bw = b;
    tick(4);
    nrst = 1;
    tick(1);
    sup = ~s;
    fsel = ~m;
    bw = ~b;
  endtask : rst

  initial begin
    {nrst, sel, we, ub, lb, sup, fsel, bw, addr, wdata} = '0;
    rst(1, 1, 1);
    chk("lock_state", LK_ACQ, lk);
    chk("factor", 16'h0190, fac);
    for (i = 0; i < 2700 && locked !== 1'b1; i++) tick(1);
    chk("locked", 1, locked);
    chk("baud_en", 1, baud_en);
    wr(8'hFA, 16'h0100, 1, 0);
    n_sys = 0;
    n_baud = 0;
    repeat (20) begin
      n_sys += sys_en;
      n_baud += baud_en;
      tick(1);
    end
    chk("sys_pulses", 10, n_sys);
    chk("baud_pulses", 20, n_baud);
    chk("locked_div", 1, locked);
    // software keeps every factor here high enough for the loop
    foreach (rows[k]) begin
      wr(8'hF8, rows[k][0], 1, 1);
      rchk(8'hF8, rows[k][1]);
      chk("drive", rows[k][2], drv);
      chk("hold_high", rows[k][3], hold_hi);
    end
    chk("lock_drop", 0, locked);
    chk("sys_stop", 0, sys_en);
    chk("baud_stop", 0, baud_en);
    rst(0, 1, 1);
    rchk(8'hF8, 16'h0000);
    // a divide value must not slow the reference path
    wr(8'hFA, 16'h0300, 1, 0);
    n_sys = 0;
    repeat (4) begin
      n_sys += sys_en;
      tick(1);
    end
    chk("sys_direct", 4, n_sys);
    chk("baud_direct", 1, baud_en);
    wr(8'hF8, 16'h1000, 1, 1);
    rchk(8'hF8, 16'h0000);
    rst(1, 0, 0);
    chk("factor_x4", 16'h0003, fac);
    wr(8'hF8, 16'h0007, 0, 1);
    chk("staged", 16'h0003, fac);
    wr(8'hF8, 16'h1000, 1, 0);
    chk("commit", 16'h0007, fac);
    wr(8'hFA, 16'h8200, 1, 0);
    wr(8'hFA, 16'h0300, 1, 0);
    rchk(8'hFA, 16'h8200);
    rchk(8'h40, 16'h0000);
    close_out;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    close_out;
  end
endmodule : tb_pll_clock_synthesis_control
